// ==== rtl/adcpp_defs.vh ====
// register map, field positions, reset values and timing counts
// for the converter result and post-processing block
`ifndef ADCPP_DEFS_VH
`define ADCPP_DEFS_VH
`define ADCPP_A_STATUS   32'hffff0500
`define ADCPP_A_MODE     32'hffff0504
`define ADCPP_A_CONFIG   32'hffff0508
`define ADCPP_A_CTRL     32'hffff050c
`define ADCPP_A_CUR_RES  32'hffff0520
`define ADCPP_A_VLT_RES  32'hffff0524
`define ADCPP_A_TMP_RES  32'hffff0528
`define ADCPP_A_CUR_OFS  32'hffff0530
`define ADCPP_A_VLT_OFS  32'hffff0534
`define ADCPP_A_TMP_OFS  32'hffff0538
`define ADCPP_A_CUR_GN   32'hffff053c
`define ADCPP_A_VLT_GN   32'hffff0540
`define ADCPP_A_TMP_GN   32'hffff0544
`define ADCPP_A_RC_LIM   32'hffff0548
`define ADCPP_A_RC_VAL   32'hffff054c
`define ADCPP_A_THRESH   32'hffff0550
`define ADCPP_A_HIT_LIM  32'hffff0554
`define ADCPP_A_HIT_CNT  32'hffff0558
`define ADCPP_A_ACCUM    32'hffff055c
`define ADCPP_RST_RC_LIM  16'h0001
`define ADCPP_RST_HIT_LIM 8'h01
`define ADCPP_ST_CMP     3
`define ADCPP_MD_ON      7
`define ADCPP_MD_CH_LO   4
`define ADCPP_MD_CH_HI   6
`define ADCPP_MODE_IDLE  3'h3
`define ADCPP_MODE_OCAL  3'h4
`define ADCPP_MODE_GCAL  3'h5
`define ADCPP_CF_RCEN    0
`define ADCPP_CF_CMP_LO  3
`define ADCPP_CF_CMP_HI  4
`define ADCPP_CF_ACC_LO  5
`define ADCPP_CF_ACC_HI  6
`define ADCPP_CMP_OFF    2'h0
`define ADCPP_CMP_ANY    2'h1
`define ADCPP_CMP_CLR    2'h2
`define ADCPP_CMP_DEC    2'h3
`define ADCPP_ACC_ON     2'h2
`define ADCPP_CC_ON      15
`define ADCPP_CC_TWOS    14
`define ADCPP_CLK_MHZ    125
`define ADCPP_IDLE_NS    23000
`define ADCPP_IDLE_CYC   ((`ADCPP_IDLE_NS*`ADCPP_CLK_MHZ+999)/1000)
`endif

// ==== rtl/adcpp_regs.v ====
// result, calibration and post-processing registers on an apb slave
// assumes results and calibration words arrive as one-cycle strobes
// from converter logic on the same clock
// Summary of operation
// [R01] current result held; not overwritten while its ready flag set
// [R02] reading current result clears all three ready flags
// [R03] voltage result not updated while its ready flag set
// [R04] with current channel off, voltage read clears voltage/temp flags
// [R05] temperature result held while flag set; its read clears flag
// [R06] offset words load factory value, replaced by offset calibration
// [R07] gain words load factory value, replaced by gain calibration
// [R08] calibration writes only when enabled and idle 23us or more
// [R09] result-count limit, reset one, used only when counter enabled
// [R10] result counter counts current conversions, wraps to zero at the limit
// [R11] writes of control or mode register clear the result counter
// [R12] threshold compares magnitude, 16 bits unipolar, 15 bits signed
// [R13] hit counter up on reach, down or cleared below threshold
// [R14] threshold flag and event when hit count equals hit limit
// [R15] accumulator cleared when disabled or current channel reconfigured
// [R16] software checks current ready flag before reading accumulator
// [R17] comparator field: off, any-hit event, count-clear, count-decrement
// [R18] with result counting on, current event only at the limit
// [R19] accumulate adds positive results, subtracts negative magnitudes
// [R20] result with flag clear is stored and flag set same cycle
// [R21] writes to read-only registers are ignored
`timescale 1ns/1ps
`include "adcpp_defs.vh"
module adcpp_regs #(
  parameter [15:0] CUR_OFS_DEF = 16'h8000,
  parameter [15:0] VLT_OFS_DEF = 16'h8000,
  parameter [15:0] TMP_OFS_DEF = 16'h8000,
  parameter [15:0] CUR_GN_DEF  = 16'h5555,
  parameter [15:0] VLT_GN_DEF  = 16'h5555,
  parameter [15:0] TMP_GN_DEF  = 16'h5555
) (
  input  wire        i_ref_clk,
  input  wire        i_sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        i_cur_valid,
  input  wire [15:0] i_cur_data,
  input  wire        i_vlt_valid,
  input  wire [15:0] i_vlt_data,
  input  wire        i_tmp_valid,
  input  wire [15:0] i_tmp_data,
  input  wire        i_cal_valid,
  input  wire [1:0]  i_cal_chan,
  input  wire        i_cal_gain,
  input  wire [15:0] i_cal_data,
  output reg         o_cur_event,
  output reg         o_cmp_event,
  output reg         o_cal_start
);

  reg [15:0] cur_res_r;
  reg [15:0] vlt_res_r;
  reg [15:0] tmp_res_r;
  reg [2:0]  rdy_r;
  reg        cmp_flag_r;
  reg [15:0] ofs_r [0:2];
  reg [15:0] gn_r  [0:2];
  reg [15:0] mode_r;
  reg [15:0] cfg_r;
  reg [15:0] ctrl_r;
  reg [15:0] rc_lim_r;
  reg [15:0] rc_val_r;
  reg [15:0] thresh_r;
  reg [7:0]  hit_lim_r;
  reg [7:0]  hit_cnt_r;
  reg [31:0] acc_r;
  reg [11:0] idle_cnt_r;
  reg [31:0] rd_nxt;
  reg        hit_r;
  reg        err_nxt;
  reg [7:0]  hit_nxt;
  reg [15:0] rc_nxt;

  wire [1:0] cmp_mode = cfg_r[`ADCPP_CF_CMP_HI:`ADCPP_CF_CMP_LO];
  wire [1:0] acc_mode = cfg_r[`ADCPP_CF_ACC_HI:`ADCPP_CF_ACC_LO];
  wire       twos     = ctrl_r[`ADCPP_CC_TWOS];
  wire       cur_on   = ctrl_r[`ADCPP_CC_ON];
  wire       setup    = psel & ~penable & ~pready;
  wire       done     = psel & penable & pready;
  wire       wr       = done & pwrite;
  wire       rd       = done & ~pwrite;

  // magnitude of a current result in the selected coding
  function [15:0] mag;
    input [15:0] d;
    input        s;
    begin
      if (s && d[15])
        mag = (~d) + 16'h0001;
      else
        mag = d;
    end
  endfunction

  wire [15:0] cur_mag = mag(i_cur_data, twos);
  wire [15:0] th_cmp  = twos ? {1'b0, thresh_r[14:0]} : thresh_r; // [R12]
  wire        reach   = cur_mag >= th_cmp;                          // [R12]

  wire [31:0] acc_add = (twos && i_cur_data[15]) ?
                        {{16{1'b1}}, i_cur_data} :
                        {16'h0000, i_cur_data};

  wire wr_mode = wr && paddr == `ADCPP_A_MODE;
  wire wr_ctrl = wr && paddr == `ADCPP_A_CTRL;
  wire wr_cfg  = wr && paddr == `ADCPP_A_CONFIG;

  wire idle    = mode_r[`ADCPP_MD_ON] &&
                 mode_r[2:0] == `ADCPP_MODE_IDLE;
  // cal words are only writable after the converter has settled in idle
  wire cal_ok  = idle && idle_cnt_r >= `ADCPP_IDLE_CYC;             // [R08]

  // read-clear masks for the three ready flags
  wire rd_cur  = rd && paddr == `ADCPP_A_CUR_RES;
  wire rd_vlt  = rd && paddr == `ADCPP_A_VLT_RES;
  wire rd_tmp  = rd && paddr == `ADCPP_A_TMP_RES;
  wire [2:0] rdy_clr = rd_cur ? 3'h7 :                              // [R02]
                       (rd_vlt && !cur_on) ? 3'h6 :                 // [R04]
                       rd_tmp ? 3'h4 : 3'h0;                        // [R05]

  // a flag cleared this cycle frees its register for a new result
  wire [2:0] rdy_free = ~rdy_r | rdy_clr;
  wire [2:0] rdy_set  = {i_tmp_valid, i_vlt_valid, i_cur_valid} &
                        rdy_free;

  always @*
  begin
    rd_nxt  = 32'h00000000;
    err_nxt = 1'b0;
    case (paddr)
      `ADCPP_A_STATUS:  rd_nxt = {28'h0000000, cmp_flag_r, rdy_r};
      `ADCPP_A_MODE:    rd_nxt = {16'h0000, mode_r};
      `ADCPP_A_CONFIG:  rd_nxt = {16'h0000, cfg_r};
      `ADCPP_A_CTRL:    rd_nxt = {16'h0000, ctrl_r};
      `ADCPP_A_CUR_RES: rd_nxt = {16'h0000, cur_res_r};
      `ADCPP_A_VLT_RES: rd_nxt = {16'h0000, vlt_res_r};
      `ADCPP_A_TMP_RES: rd_nxt = {16'h0000, tmp_res_r};
      `ADCPP_A_CUR_OFS: rd_nxt = {16'h0000, ofs_r[0]};
      `ADCPP_A_VLT_OFS: rd_nxt = {16'h0000, ofs_r[1]};
      `ADCPP_A_TMP_OFS: rd_nxt = {16'h0000, ofs_r[2]};
      `ADCPP_A_CUR_GN:  rd_nxt = {16'h0000, gn_r[0]};
      `ADCPP_A_VLT_GN:  rd_nxt = {16'h0000, gn_r[1]};
      `ADCPP_A_TMP_GN:  rd_nxt = {16'h0000, gn_r[2]};
      `ADCPP_A_RC_LIM:  rd_nxt = {16'h0000, rc_lim_r};
      `ADCPP_A_RC_VAL:  rd_nxt = {16'h0000, rc_val_r};
      `ADCPP_A_THRESH:  rd_nxt = {16'h0000, thresh_r};
      `ADCPP_A_HIT_LIM: rd_nxt = {24'h000000, hit_lim_r};
      `ADCPP_A_HIT_CNT: rd_nxt = {24'h000000, hit_cnt_r};
      `ADCPP_A_ACCUM:   rd_nxt = acc_r;
      default:          err_nxt = 1'b1;
    endcase
  end

  // next hit count; holds at the top rather than wrapping back to zero
  always @*
  begin
    hit_nxt = hit_cnt_r;
    case (cmp_mode)
      `ADCPP_CMP_CLR, `ADCPP_CMP_DEC:
      begin
        if (reach)
        begin
          if (hit_cnt_r != 8'hff)
            hit_nxt = hit_cnt_r + 8'h01;                            // [R13]
        end
        else if (cmp_mode == `ADCPP_CMP_CLR)
          hit_nxt = 8'h00;                                          // [R17]
        else if (hit_cnt_r != 8'h00)
          hit_nxt = hit_cnt_r - 8'h01;                              // [R17]
      end
      default:
        hit_nxt = hit_cnt_r;
    endcase
  end

  always @*
  begin
    rc_nxt = rc_val_r + 16'h0001;                                   // [R10]
    if (rc_nxt == rc_lim_r)
      rc_nxt = 16'h0000;                                            // [R10]
  end

  // apb: zero wait state, pready raised in the cycle after setup
  always @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      if (setup)
      begin
        prdata  <= pwrite ? 32'h00000000 : rd_nxt;
        pslverr <= err_nxt;
      end
      else if (done)
      begin
        prdata  <= 32'h00000000;
        pslverr <= 1'b0;
      end
    end
  end

  // results and ready flags; a new result wins over a read-clear
  always @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      cur_res_r <= 16'h0000;
      vlt_res_r <= 16'h0000;
      tmp_res_r <= 16'h0000;
      rdy_r     <= 3'h0;
    end
    else
    begin
      if (rdy_set[0])
        cur_res_r <= i_cur_data;                                    // [R01] [R20]
      if (rdy_set[1])
        vlt_res_r <= i_vlt_data;                                    // [R03] [R20]
      if (rdy_set[2])
        tmp_res_r <= i_tmp_data;                                    // [R05] [R20]
      rdy_r <= (rdy_r & ~rdy_clr) | rdy_set;                        // [R20]
    end
  end

  // control registers written by software
  always @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      mode_r    <= 16'h0000;
      cfg_r     <= 16'h0000;
      ctrl_r    <= 16'h0000;
      rc_lim_r  <= `ADCPP_RST_RC_LIM;                               // [R09]
      thresh_r  <= 16'h0000;
      hit_lim_r <= `ADCPP_RST_HIT_LIM;                              // [R14]
    end
    else if (wr)
    begin
      case (paddr)
        `ADCPP_A_MODE:    mode_r    <= pwdata[15:0];
        `ADCPP_A_CONFIG:  cfg_r     <= pwdata[15:0];
        `ADCPP_A_CTRL:    ctrl_r    <= pwdata[15:0];
        `ADCPP_A_RC_LIM:  rc_lim_r  <= pwdata[15:0];                // [R09]
        `ADCPP_A_THRESH:  thresh_r  <= pwdata[15:0];
        `ADCPP_A_HIT_LIM: hit_lim_r <= pwdata[7:0];
        default:          thresh_r  <= thresh_r;                    // [R21]
      endcase
    end
  end

  // idle time counter, saturates once writes are allowed
  always @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      idle_cnt_r <= 12'h000;
    else if (!idle || wr_mode)
      idle_cnt_r <= 12'h000;                                        // [R08]
    else if (idle_cnt_r < `ADCPP_IDLE_CYC)
      idle_cnt_r <= idle_cnt_r + 12'h001;
  end

  // calibration words: factory value at reset, then calibration or
  // software; a calibration result wins over a same-cycle write
  integer k;
  always @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ofs_r[0] <= CUR_OFS_DEF;                                      // [R06]
      ofs_r[1] <= VLT_OFS_DEF;
      ofs_r[2] <= TMP_OFS_DEF;
      gn_r[0]  <= CUR_GN_DEF;                                       // [R07]
      gn_r[1]  <= VLT_GN_DEF;
      gn_r[2]  <= TMP_GN_DEF;
    end
    else
    begin
      for (k = 0; k < 3; k = k + 1)
      begin
        if (i_cal_valid && i_cal_chan == k[1:0])
        begin
          if (i_cal_gain)
            gn_r[k] <= i_cal_data;                                  // [R07]
          else
            ofs_r[k] <= i_cal_data;                                 // [R06]
        end
        else if (wr && cal_ok)
        begin
          if (paddr == `ADCPP_A_CUR_OFS + 4 * k)
            ofs_r[k] <= pwdata[15:0];                               // [R08]
          if (paddr == `ADCPP_A_CUR_GN + 4 * k)
            gn_r[k] <= pwdata[15:0];                                // [R08]
        end
      end
    end
  end

  // calibration request toward the converter on a cal mode write
  always @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_cal_start <= 1'b0;
    else
      o_cal_start <= wr_mode && pwdata[`ADCPP_MD_ON] &&
                     (pwdata[2:0] == `ADCPP_MODE_OCAL ||
                      pwdata[2:0] == `ADCPP_MODE_GCAL) &&
                     pwdata[`ADCPP_MD_CH_HI:`ADCPP_MD_CH_LO] != 3'h0;
  end

  // result counter and current-channel event
  always @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      rc_val_r    <= 16'h0000;
      o_cur_event <= 1'b0;
    end
    else
    begin
      o_cur_event <= 1'b0;
      // reconfiguration wins over a same-cycle conversion
      if (wr_mode || wr_ctrl)
        rc_val_r <= 16'h0000;                                       // [R11]
      else if (i_cur_valid && cfg_r[`ADCPP_CF_RCEN])
      begin
        rc_val_r    <= rc_nxt;                                      // [R10]
        o_cur_event <= rc_nxt == 16'h0000;                          // [R18] [R09]
      end
      else if (i_cur_valid)
        o_cur_event <= 1'b1;
    end
  end

  // comparator, hit counter and threshold flag
  always @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      hit_cnt_r   <= 8'h00;
      cmp_flag_r  <= 1'b0;
      o_cmp_event <= 1'b0;
      hit_r       <= 1'b0;
    end
    else
    begin
      o_cmp_event <= 1'b0;
      hit_r       <= 1'b0;
      if (i_cur_valid)
      begin
        hit_cnt_r <= hit_nxt;                                       // [R13]
        if (cmp_mode == `ADCPP_CMP_ANY && reach)
          hit_r <= 1'b1;                                            // [R17]
        else if (cmp_mode[1] && hit_nxt == hit_lim_r)
          hit_r <= 1'b1;                                            // [R14]
      end
      // status read clears the flag, but a new hit wins
      if (hit_r)
      begin
        cmp_flag_r  <= 1'b1;                                        // [R14]
        o_cmp_event <= 1'b1;
      end
      else if (rd && paddr == `ADCPP_A_STATUS)
        cmp_flag_r <= 1'b0;
    end
  end

  // accumulator; totals wrap in two's complement on overflow
  always @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      acc_r <= 32'h00000000;
    else if (acc_mode != `ADCPP_ACC_ON || wr_ctrl)
      acc_r <= 32'h00000000;                                        // [R15]
    else if (i_cur_valid)
      acc_r <= acc_r + acc_add;                                     // [R19]
  end

endmodule // adcpp_regs

// ==== sim/adcpp_regs_props.sv ====
// concurrent checks on the apb and event ports of the result block
// bound to every adcpp_regs instance; one clock, async high reset
`timescale 1ns/1ps
`include "adcpp_defs.vh"
module adcpp_regs_props (
  input wire        i_ref_clk,
  input wire        i_sys_rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        i_cur_valid,
  input wire        o_cur_event,
  input wire        o_cmp_event,
  input wire        o_cal_start
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_unmapped_err: assert property
    (psel && !penable && paddr == 32'hffff0510 |=> pslverr)
    else $error("unmapped access not refused");
  a_mapped_no_err: assert property (
    psel && !penable && paddr == `ADCPP_A_CUR_RES |=> !pslverr)
    else $error("mapped access refused");
  a_cur_event_cause: assert property (
    o_cur_event |-> $past(i_cur_valid))
    else $error("current event without result");
  a_cmp_event_cause: assert property (
    o_cmp_event |-> $past(i_cur_valid, 2))
    else $error("comparator event without result");
  a_cal_start_cause: assert property (
    o_cal_start |-> $past(psel && penable && pwrite
                          && paddr == `ADCPP_A_MODE))
    else $error("calibration start without mode write");
endmodule // adcpp_regs_props

bind adcpp_regs adcpp_regs_props adcpp_regs_props_inst (
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .i_cur_valid(i_cur_valid), .o_cur_event(o_cur_event),
  .o_cmp_event(o_cmp_event), .o_cal_start(o_cal_start));

// ==== sim/adcpp_conv_model.sv ====
// converter stand-in: bench requests become one-cycle result strobes
// data lines invert each cycle outside a strobe, so a stale value matches only every other cycle
`timescale 1ns/1ps
module adcpp_conv_model (
  input  wire        i_ref_clk,
  input  wire [2:0]  i_req,
  input  wire [15:0] i_val,
  output reg         o_cur_valid = 1'b0,
  output reg         o_vlt_valid = 1'b0,
  output reg         o_tmp_valid = 1'b0,
  output reg  [15:0] o_cur_data = 16'h0,
  output reg  [15:0] o_vlt_data = 16'h0,
  output reg  [15:0] o_tmp_data = 16'h0
);
  always @(posedge i_ref_clk)
  begin
    {o_tmp_valid, o_vlt_valid, o_cur_valid} <= i_req;
    o_cur_data <= i_req[0] ? i_val : ~o_cur_data;
    o_vlt_data <= i_req[1] ? i_val : ~o_vlt_data;
    o_tmp_data <= i_req[2] ? i_val : ~o_tmp_data;
  end
endmodule // adcpp_conv_model

// ==== sim/tb_top.sv ====
// self-checking bench for the result and post-processing registers
// apb master tasks; result strobes come through the converter model
`timescale 1ns/1ps
`include "adcpp_defs.vh"
module tb_top;
  logic        i_ref_clk = 0;
  logic        i_sys_rst = 1;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [31:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cv, vv, tv, ce, me, cs;
  logic [15:0] cd, vd, td;
  logic [2:0]  req = 0;
  logic [15:0] rval = 0;
  logic        cal_v = 0;
  logic [1:0]  cal_c = 0;
  logic        cal_g = 0;
  logic [15:0] cal_d = 0;
  logic [31:0] rdat;
  logic        rerr;
  int          errors = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          n_cur = 0;
  int          n_cmp = 0;
  int          n_cal = 0;
  int          c0 = 0;
  int          m0 = 0;

  adcpp_regs #(.CUR_OFS_DEF(16'h1111), .TMP_GN_DEF(16'h2222))
  adcpp_regs_inst (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .i_cur_valid(cv), .i_cur_data(cd),
    .i_vlt_valid(vv), .i_vlt_data(vd), .i_tmp_valid(tv),
    .i_tmp_data(td), .i_cal_valid(cal_v), .i_cal_chan(cal_c),
    .i_cal_gain(cal_g), .i_cal_data(cal_d), .o_cur_event(ce),
    .o_cmp_event(me), .o_cal_start(cs));
  adcpp_conv_model adcpp_conv_model_inst (.i_ref_clk(i_ref_clk),
    .i_req(req), .i_val(rval), .o_cur_valid(cv), .o_vlt_valid(vv),
    .o_tmp_valid(tv), .o_cur_data(cd), .o_vlt_data(vd),
    .o_tmp_data(td));

  always #4 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk)
  begin
    cyc <= cyc + 1;
    n_cur <= n_cur + (ce === 1'b1);
    n_cmp <= n_cmp + (me === 1'b1);
    n_cal <= n_cal + (cs === 1'b1);
    if (cyc == 20000)
    begin
      errors++;
      conclude;
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // request stands until the rising edge that samples pready high;
  // read data and response are taken at that same edge
  task automatic apb(input logic w, input logic [31:0] a, d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_ref_clk);
    penable <= 1;
    do
      @(posedge i_ref_clk);
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge i_ref_clk);
  endtask
  task automatic rdc(input string nm, input logic [31:0] a, e);
    apb(0, a, 0);
    chk(nm, rdat, e);
  endtask
  task automatic strobe(input logic [2:0] ch, input logic [15:0] v);
    req <= ch;
    rval <= v;
    @(posedge i_ref_clk);
    req <= 0;
    repeat (3) @(posedge i_ref_clk);
  endtask
  task automatic cur(input logic [15:0] v);
    strobe(3'b001, v);
    apb(0, `ADCPP_A_CUR_RES, 0);
  endtask
  task automatic cal(input logic [1:0] c, input logic g,
                     input logic [15:0] v);
    cal_v <= 1;
    cal_c <= c;
    cal_g <= g;
    cal_d <= v;
    @(posedge i_ref_clk);
    cal_v <= 0;
    @(posedge i_ref_clk);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge i_ref_clk);
    i_sys_rst <= 0;
    @(posedge i_ref_clk);
    rdc("cur_res", `ADCPP_A_CUR_RES, 0);
    rdc("rc_lim", `ADCPP_A_RC_LIM, 1);
    rdc("hit_lim", `ADCPP_A_HIT_LIM, 1);
    rdc("cur_ofs", `ADCPP_A_CUR_OFS, 32'h1111);
    rdc("tmp_gn", `ADCPP_A_TMP_GN, 32'h2222);
    rdc("accum", `ADCPP_A_ACCUM, 0);
    $display("test reset_values done");
    strobe(1, 16'h1234);
    strobe(1, 16'h5678);
    rdc("status", `ADCPP_A_STATUS, 1);
    rdc("cur_res", `ADCPP_A_CUR_RES, 32'h1234);
    rdc("status", `ADCPP_A_STATUS, 0);
    strobe(3'b110, 16'h0a0a);
    strobe(2, 16'h0b0b);
    rdc("vlt_res", `ADCPP_A_VLT_RES, 32'h0a0a);
    rdc("status", `ADCPP_A_STATUS, 0);
    strobe(4, 16'h0c0c);
    strobe(4, 16'h0d0d);
    rdc("tmp_res", `ADCPP_A_TMP_RES, 32'h0c0c);
    rdc("status", `ADCPP_A_STATUS, 0);
    apb(1, `ADCPP_A_CTRL, 32'h8000);
    strobe(2, 16'h0e0e);
    rdc("vlt_res", `ADCPP_A_VLT_RES, 32'h0e0e);
    rdc("status", `ADCPP_A_STATUS, 2);
    apb(0, `ADCPP_A_CUR_RES, 0);
    apb(1, `ADCPP_A_VLT_RES, 32'h5555);
    rdc("vlt_res", `ADCPP_A_VLT_RES, 32'h0e0e);
    apb(0, 32'hffff0510, 0);
    chk("slverr", rerr, 1);
    $display("test ready_flags done");
    c0 = n_cur;
    cur(16'h0001);
    chk("ev_plain", n_cur - c0, 1);
    apb(1, `ADCPP_A_CONFIG, 1);
    apb(1, `ADCPP_A_RC_LIM, 3);
    apb(1, `ADCPP_A_CTRL, 32'h8000);
    c0 = n_cur;
    cur(1);
    cur(1);
    rdc("rc_val", `ADCPP_A_RC_VAL, 2);
    chk("ev_masked", n_cur - c0, 0);
    cur(1);
    chk("ev_limit", n_cur - c0, 1);
    rdc("rc_val", `ADCPP_A_RC_VAL, 0);
    cur(1);
    apb(1, `ADCPP_A_CTRL, 32'h8000);
    rdc("rc_val", `ADCPP_A_RC_VAL, 0);
    $display("test result_counter done");
    apb(1, `ADCPP_A_THRESH, 32'h0100);
    apb(1, `ADCPP_A_HIT_LIM, 2);
    apb(1, `ADCPP_A_CONFIG, 32'h10);
    m0 = n_cmp;
    cur(16'h0200);
    cur(16'h0300);
    rdc("hit_cnt", `ADCPP_A_HIT_CNT, 2);
    chk("cmp_ev", n_cmp - m0, 1);
    cur(16'h0050);
    rdc("hit_cnt", `ADCPP_A_HIT_CNT, 0);
    apb(1, `ADCPP_A_HIT_CNT, 32'h55);
    rdc("hit_cnt", `ADCPP_A_HIT_CNT, 0);
    apb(1, `ADCPP_A_CONFIG, 32'h18);
    cur(16'h0200);
    cur(16'h0100);
    cur(16'h00ff);
    rdc("hit_cnt", `ADCPP_A_HIT_CNT, 1);
    chk("cmp_ev", n_cmp - m0, 2);
    apb(1, `ADCPP_A_CONFIG, 32'h08);
    cur(16'h00ff);
    cur(16'h0100);
    chk("cmp_ev", n_cmp - m0, 3);
    apb(1, `ADCPP_A_CONFIG, 0);
    cur(16'h0200);
    apb(1, `ADCPP_A_THRESH, 32'h8100);
    apb(1, `ADCPP_A_CONFIG, 32'h08);
    cur(16'h0200);
    chk("cmp_ev", n_cmp - m0, 3);
    apb(1, `ADCPP_A_CTRL, 32'hc000);
    cur(16'h0200);
    chk("cmp_ev", n_cmp - m0, 4);
    $display("test comparator done");
    apb(1, `ADCPP_A_CONFIG, 32'h40);
    cur(16'h0030);
    strobe(1, 16'hfff0);
    // threshold flag from the comparator test is still up: no status
    // read has cleared it since
    rdc("status", `ADCPP_A_STATUS, 32'h9);
    rdc("accum", `ADCPP_A_ACCUM, 32'h20);
    apb(0, `ADCPP_A_CUR_RES, 0);
    apb(1, `ADCPP_A_CTRL, 32'hc000);
    rdc("accum", `ADCPP_A_ACCUM, 0);
    cur(16'h0030);
    apb(1, `ADCPP_A_CONFIG, 0);
    rdc("accum", `ADCPP_A_ACCUM, 0);
    $display("test accumulator done");
    apb(1, `ADCPP_A_CUR_OFS, 32'h0f0f);
    rdc("cur_ofs", `ADCPP_A_CUR_OFS, 32'h1111);
    apb(1, `ADCPP_A_MODE, 32'h83);
    apb(1, `ADCPP_A_CUR_OFS, 32'h0f0f);
    rdc("cur_ofs", `ADCPP_A_CUR_OFS, 32'h1111);
    // software side keeps the converter idle past the 23 us window
    repeat (2900) @(posedge i_ref_clk);
    apb(1, `ADCPP_A_CUR_OFS, 32'h0f0f);
    rdc("cur_ofs", `ADCPP_A_CUR_OFS, 32'h0f0f);
    apb(1, `ADCPP_A_MODE, 32'h94);
    repeat (2) @(posedge i_ref_clk);
    chk("cal_start", n_cal, 1);
    cal(0, 0, 16'h4444);
    rdc("cur_ofs", `ADCPP_A_CUR_OFS, 32'h4444);
    cal(2, 1, 16'h7777);
    rdc("tmp_gn", `ADCPP_A_TMP_GN, 32'h7777);
    $display("test calibration done");
    conclude;
  end
endmodule // tb_top
